// ===== verilog/bt_host_power_handshake.sv
// Purpose: wake handshake, clock request, start-up and RF power-down control
// Assumes: pins arrive asynchronous; baseband inputs share mclk
// Notes:   registers over Avalon-MM, one wait state on every access
//
// Functional notes
// - asserted device wake keeps or makes us awake
// - deasserted wake: sleep only when criteria met
// - wake line polarities chosen by software
// - host wake asserted when host attention needed
// - clock request high while any subsystem needs it
// - after init, RTS low follows CTS low quickly
// - clock request rises soon after power enable
// - separate power-downs: tx, rx, synth, amplifier
// - power actions from software or packet activity
// - wake lines only in serial mode, enabled
// - pad function select zero enables handshake pins
// - power-on reset held while power enable low
//
// Added by the designer: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none

module bt_host_power_handshake
	import bt_pwr_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        reset_n,
	// pins
	input  wire logic        radio_power_enable,
	input  wire logic        device_wake_request,
	input  wire logic        serial_clear_to_send_n,
	output var  logic        host_wake_request,
	output var  logic        ref_clk_request,
	output var  logic        serial_request_to_send_n,
	// baseband core, same clock
	input  wire logic        bb_tx_active,
	input  wire logic        bb_rx_active,
	input  wire logic        bb_sleep_ok,
	input  wire logic        bb_host_attention,
	input  wire logic        wlan_clk_need,
	output var  rf_pd_t      rf_power_down,
	output var  logic        por_active,
	// register port
	input  wire logic [4:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [3:0]  byteenable,
	input  wire logic [31:0] writedata,
	output var  logic [31:0] readdata,
	output var  logic        waitrequest,
	output var  logic        irq
);

	// =====================================================================
	// elaboration checks
	generate
		if (INIT_CYC >= 65536) begin : g_bad_init
			$error("start-up count does not fit the counter");
		end
		if (T4_CYC < RESP_LAT || T5_CYC < RESP_LAT) begin : g_bad_bound
			$error("response bound shorter than pin latency");
		end
	endgenerate

	core_state_t s;
	core_state_t n;

	logic             usable;
	logic             wake_in;
	logic             host_wake_act;
	logic             bb_busy;
	logic             awake;
	logic             init_done;
	logic             bus_go;
	logic [IRQ_W-1:0] ev;
	logic [IRQ_W-1:0] w1c;
	logic [31:0]      rdata;

	// =====================================================================
	// next state
	always_comb begin
		n = s;

		// pin synchronisers; only the second stage, and for CTS its delayed copy cts_prev, is read below
		n.wake_s1  = device_wake_request;
		n.wake_s2  = s.wake_s1;
		n.cts_s1   = serial_clear_to_send_n;
		n.cts_s2   = s.cts_s1;
		n.cts_prev = s.cts_s2;
		n.pwr_s1   = radio_power_enable;
		n.pwr_s2   = s.pwr_s1;

		// handshake lines mean nothing outside serial mode or on other pad use
		usable = s.ctrl[CTRL_HS_EN] & s.ctrl[CTRL_UART_MODE]
		       & (s.pad_sel == PAD_FUNC_HANDSHAKE);
		wake_in = usable & (s.wake_s2 == s.ctrl[CTRL_WAKE_IN_POL]);

		bb_busy   = bb_tx_active | bb_rx_active;
		awake     = (s.state == PS_AWAKE);
		init_done = (s.state == PS_AWAKE) || (s.state == PS_SLEEP);
		ev        = '0;

		// host attention stays pending until the host raises device wake;
		// a new request in the same cycle wins over that clear
		n.attn = bb_host_attention | (s.attn & ~wake_in);
		host_wake_act = usable & (s.state != PS_OFF)
		              & (s.attn | s.ctrl[CTRL_HOST_WAKE_SW]);

		case (s.state)
			PS_OFF: begin
				n.cnt = '0;
				if (s.pwr_s2) begin
					n.state = PS_START;
				end
			end
			PS_START: begin
				n.cnt = s.cnt + 16'h0001;
				if (s.cnt == 16'(INIT_CYC - 1)) begin
					n.state = PS_AWAKE;
					n.cnt   = '0;
					ev[IRQ_POR_DONE] = 1'b1;
				end
			end
			PS_AWAKE: begin
				// sleep needs wake deasserted plus every local criterion
				if (!wake_in && s.ctrl[CTRL_SLEEP_OK] && bb_sleep_ok && !bb_busy
				    && !s.ctrl[CTRL_FORCE_WAKE] && !host_wake_act) begin
					n.state = PS_SLEEP;
					ev[IRQ_SLEPT] = 1'b1;
				end
			end
			PS_SLEEP: begin
				if (wake_in || bb_busy || s.ctrl[CTRL_FORCE_WAKE] || host_wake_act) begin
					n.state = PS_AWAKE;
					ev[IRQ_WOKE] = 1'b1;
				end
			end
			default: begin
				n.state = PS_OFF;
			end
		endcase

		// losing power enable drops the state, start-up count and host attention back to reset
		if (!s.pwr_s2) begin
			n.state = PS_OFF;
			n.cnt   = '0;
			n.attn  = 1'b0;
		end
		n.por = (n.state == PS_OFF);

		// out polarity: pin equals active level when polarity bit is one
		n.host_wake_pin = ~(host_wake_act ^ s.ctrl[CTRL_WAKE_OUT_POL]);

		// clock request raised on the first start-up cycle, well inside
		// the bound; the crystal build leaves it to the other subsystem
		n.clk_req = (s.ctrl[CTRL_EXT_REFCLK]
		             & ((n.state == PS_START) | (n.state == PS_AWAKE)))
		          | wlan_clk_need;

		// flow control answer only once start-up is over
		n.rts_n = ~(init_done & ~s.cts_s2);
		if (init_done && s.cts_prev && !s.cts_s2) begin
			ev[IRQ_CTS_LOW] = 1'b1;
		end

		// transceiver power-down: packet activity gates each path, software
		// can force any block down
		n.pd.tx    = ~awake | s.pd_force[3] | ~bb_tx_active;
		n.pd.rx    = ~awake | s.pd_force[2] | ~bb_rx_active;
		n.pd.synth = ~awake | s.pd_force[1] | ~bb_busy;
		n.pd.pa    = ~awake | s.pd_force[0] | ~bb_tx_active;

		// =================================================================
		// register port: waitrequest drops one cycle after the request,
		// the access completes at the edge where it is sampled low
		bus_go = (read | write) & ~s.waitrequest;
		w1c    = '0;
		rdata  = '0;
		case (address)
			CTRL_OFS:       rdata[CTRL_W-1:0] = s.ctrl;
			STATUS_OFS: begin
				rdata[ST_AWAKE]     = awake;
				rdata[ST_SLEEP]     = (s.state == PS_SLEEP);
				rdata[ST_POR]       = s.por;
				rdata[ST_CLK_REQ]   = s.clk_req;
				rdata[ST_HOST_WAKE] = host_wake_act;
				rdata[ST_WAKE_IN]   = wake_in;
				rdata[ST_USABLE]    = usable;
				rdata[ST_PD_LSB +: 4] = s.pd;
			end
			IRQ_STATUS_OFS: rdata[IRQ_W-1:0] = s.irq_status;
			IRQ_MASK_OFS:   rdata[IRQ_W-1:0] = s.irq_mask;
			PD_FORCE_OFS:   rdata[3:0]       = s.pd_force;
			PAD_SEL_OFS:    rdata[PAD_W-1:0] = s.pad_sel;
			default:        rdata = '0;
		endcase

		n.waitrequest = 1'b1;
		if ((read | write) && s.waitrequest) begin
			n.waitrequest = 1'b0;
			n.readdata    = read ? rdata : 32'h0000_0000;
		end

		if (bus_go && write && byteenable[0]) begin
			case (address)
				CTRL_OFS:       n.ctrl     = writedata[CTRL_W-1:0];
				IRQ_STATUS_OFS: w1c        = writedata[IRQ_W-1:0];
				IRQ_MASK_OFS:   n.irq_mask = writedata[IRQ_W-1:0];
				PD_FORCE_OFS:   n.pd_force = writedata[3:0];
				PAD_SEL_OFS:    n.pad_sel  = writedata[PAD_W-1:0];
				default: begin
				end
			endcase
		end

		// a new event beats a clear written in the same cycle
		n.irq_status = (s.irq_status & ~w1c) | ev;
		n.irq        = |(n.irq_status & n.irq_mask);
	end

	// =====================================================================
	// state register
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			s <= '{
				wake_s1:       1'b0,
				wake_s2:       1'b0,
				cts_s1:        1'b1,
				cts_s2:        1'b1,
				cts_prev:      1'b1,
				pwr_s1:        1'b0,
				pwr_s2:        1'b0,
				state:         PS_OFF,
				cnt:           16'h0000,
				ctrl:          CTRL_RESET,
				pad_sel:       PAD_SEL_RESET,
				pd_force:      PD_FORCE_RESET,
				irq_status:    4'h0,
				irq_mask:      IRQ_MASK_RESET,
				attn:          1'b0,
				host_wake_pin: 1'b0,
				clk_req:       1'b0,
				rts_n:         1'b1,
				pd:            4'hF,
				por:           1'b1,
				irq:           1'b0,
				waitrequest:   1'b1,
				readdata:      32'h0000_0000
			};
		end else begin
			s <= n;
		end
	end

	// =====================================================================
	// outputs, all straight from the state register
	assign host_wake_request        = s.host_wake_pin;
	assign ref_clk_request          = s.clk_req;
	assign serial_request_to_send_n = s.rts_n;
	assign rf_power_down            = s.pd;
	assign por_active               = s.por;
	assign readdata                 = s.readdata;
	assign waitrequest              = s.waitrequest;
	assign irq                      = s.irq;

endmodule

`default_nettype wire

// ===== verilog/bt_pwr_pkg.sv
// Purpose: constants and types shared by the radio power handshake block
// Assumes: 100 MHz core clock, 32-bit Avalon-MM register port, byte addresses
// Notes:   all timing bounds are converted to core-clock cycles here
`default_nettype none
package bt_pwr_pkg;

	// =====================================================================
	// timing
	localparam int CLK_PERIOD_NS = 10;
	// longest allowed response times; plain defaults, no figure is given
	localparam int T4_MAX_NS     = 1000;
	localparam int T5_MAX_NS     = 1000;
	// start-up time between power enable and "initialised"
	localparam int INIT_NS       = 2000;
	// cycles from a pin edge to the registered answer (2 sync + 1 output)
	localparam int RESP_LAT      = 3;

	function automatic int max_cyc(input int ns);
		return (ns / CLK_PERIOD_NS < 1) ? 1 : ns / CLK_PERIOD_NS;
	endfunction

	function automatic int min_cyc(input int ns);
		return ((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1) ? 1 :
		       (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	endfunction

	localparam int T4_CYC   = max_cyc(T4_MAX_NS);
	localparam int T5_CYC   = max_cyc(T5_MAX_NS);
	localparam int INIT_CYC = min_cyc(INIT_NS);

	// =====================================================================
	// register map (byte offsets)
	localparam logic [4:0] CTRL_OFS       = 5'h00;
	localparam logic [4:0] STATUS_OFS     = 5'h04;
	localparam logic [4:0] IRQ_STATUS_OFS = 5'h08;
	localparam logic [4:0] IRQ_MASK_OFS   = 5'h0C;
	localparam logic [4:0] PD_FORCE_OFS   = 5'h10;
	localparam logic [4:0] PAD_SEL_OFS    = 5'h14;

	// control bits
	localparam int CTRL_HS_EN        = 0;
	localparam int CTRL_UART_MODE    = 1;
	localparam int CTRL_WAKE_IN_POL  = 2;
	localparam int CTRL_WAKE_OUT_POL = 3;
	localparam int CTRL_EXT_REFCLK   = 4;
	localparam int CTRL_HOST_WAKE_SW = 5;
	localparam int CTRL_SLEEP_OK     = 6;
	localparam int CTRL_FORCE_WAKE   = 7;
	localparam int CTRL_W            = 8;
	localparam logic [7:0] CTRL_RESET = 8'h1C;

	// status bits
	localparam int ST_AWAKE     = 0;
	localparam int ST_SLEEP     = 1;
	localparam int ST_POR       = 2;
	localparam int ST_CLK_REQ   = 3;
	localparam int ST_HOST_WAKE = 4;
	localparam int ST_WAKE_IN   = 5;
	localparam int ST_USABLE    = 6;
	localparam int ST_PD_LSB    = 8;

	// interrupt bits
	localparam int IRQ_WOKE      = 0;
	localparam int IRQ_SLEPT     = 1;
	localparam int IRQ_POR_DONE  = 2;
	localparam int IRQ_CTS_LOW   = 3;
	localparam int IRQ_W         = 4;
	localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

	// pad function select: zero selects the handshake function
	localparam int PAD_W = 3;
	localparam logic [2:0] PAD_FUNC_HANDSHAKE = 3'h0;
	localparam logic [2:0] PAD_SEL_RESET      = 3'h0;
	localparam logic [3:0] PD_FORCE_RESET     = 4'h0;

	// =====================================================================
	// types
	typedef enum logic [1:0] {
		PS_OFF   = 2'b00,
		PS_START = 2'b01,
		PS_AWAKE = 2'b10,
		PS_SLEEP = 2'b11
	} pwr_state_t;

	// one bit per transceiver block, high = powered down
	typedef struct packed {
		logic tx;
		logic rx;
		logic synth;
		logic pa;
	} rf_pd_t;

	typedef struct packed {
		logic              wake_s1;
		logic              wake_s2;
		logic              cts_s1;
		logic              cts_s2;
		logic              cts_prev;
		logic              pwr_s1;
		logic              pwr_s2;
		pwr_state_t        state;
		logic [15:0]       cnt;
		logic [CTRL_W-1:0] ctrl;
		logic [PAD_W-1:0]  pad_sel;
		logic [3:0]        pd_force;
		logic [IRQ_W-1:0]  irq_status;
		logic [IRQ_W-1:0]  irq_mask;
		logic              attn;
		logic              host_wake_pin;
		logic              clk_req;
		logic              rts_n;
		rf_pd_t            pd;
		logic              por;
		logic              irq;
		logic              waitrequest;
		logic [31:0]       readdata;
	} core_state_t;

endpackage
`default_nettype wire

// ===== testbench/bt_pwr_assertions.sv
// Purpose: port-level checks for the power handshake block
// Assumes: one clock domain, reset_n active low
// Notes:   repeat counts leave margin for the 2-flop pin synchronisers
`timescale 1ns/1ns
`default_nettype none

module bt_pwr_assertions
	import bt_pwr_pkg::*;
(
	input wire logic   mclk,
	input wire logic   reset_n,
	input wire logic   radio_power_enable,
	input wire logic   serial_clear_to_send_n,
	input wire logic   serial_request_to_send_n,
	input wire logic   ref_clk_request,
	input wire logic   wlan_clk_need,
	input wire rf_pd_t rf_power_down,
	input wire logic   por_active,
	input wire logic   read,
	input wire logic   write,
	input wire logic   waitrequest
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	// ==========
	// sequences
	sequence s_bus_req;
		(read || write) && waitrequest;
	endsequence
	sequence s_off_idle;
		(por_active && !wlan_clk_need) [*3];
	endsequence

	// ==========
	// checks
	chk_wait_one: assert property (s_bus_req |=> !waitrequest)
		else $error("bus access did not complete after one wait state");
	chk_wait_release: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest low for more than one cycle");
	chk_por_hold: assert property (!radio_power_enable [*5] |-> por_active)
		else $error("power-on reset released while power enable low");
	chk_por_free: assert property (radio_power_enable [*5] |-> !por_active)
		else $error("power-on reset held while power enable high");
	chk_clk_need: assert property (wlan_clk_need [*3] |-> ref_clk_request)
		else $error("clock request missing while other subsystem needs it");
	chk_clk_off: assert property (s_off_idle |-> !ref_clk_request)
		else $error("clock request high with no subsystem needing it");
	chk_rf_off: assert property (por_active [*3] |-> rf_power_down == 4'hF)
		else $error("transceiver powered while in power-on reset");
	chk_rts_idle: assert property (serial_clear_to_send_n [*5] |-> serial_request_to_send_n)
		else $error("request to send low while clear to send high");
	chk_rts_off: assert property (por_active [*3] |-> serial_request_to_send_n)
		else $error("request to send low before initialisation");
endmodule

bind bt_host_power_handshake bt_pwr_assertions chk_i (
	.mclk, .reset_n, .radio_power_enable, .serial_clear_to_send_n, .serial_request_to_send_n,
	.ref_clk_request, .wlan_clk_need, .rf_power_down, .por_active, .read, .write, .waitrequest
);
`default_nettype wire

// ===== testbench/bt_host_model.sv
// Purpose: host processor at the far end of the wake lines
// Assumes: wake_pol matches the polarity bits written to the device
// Notes:   lag sets how slowly the host answers a wake request
`timescale 1ns/1ns
`default_nettype none

module bt_host_model (
	input  wire logic       mclk,
	input  wire logic       reset_n,
	input  wire logic       host_wake_request,
	input  wire logic       wake_pol,
	input  wire logic       host_need,
	input  wire logic [3:0] lag,
	output wire logic       device_wake_request
);
	logic [3:0] wait_reg;
	logic       hw_act;

	// ==========
	// wake response
	assign hw_act = host_wake_request == wake_pol;
	// lag stays below 8, so the count saturates before it wraps
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			wait_reg <= 4'h0;
		else if (!hw_act)
			wait_reg <= 4'h0;
		else if (wait_reg <= lag)
			wait_reg <= wait_reg + 4'h1;
	end
	assign device_wake_request = (host_need || wait_reg > lag) ? wake_pol : !wake_pol;
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
// Purpose: self-checking bench for the power handshake block
// Assumes: host model on the wake lines, bench drives baseband and bus
// Notes:   waits use the package bounds; random seed is fixed
`timescale 1ns/1ns
`default_nettype none

module testbench
	import bt_pwr_pkg::*;
;
	logic        mclk = 1'b0, reset_n = 1'b0, radio_power_enable = 1'b0;
	logic        serial_clear_to_send_n = 1'b1, device_wake_request;
	logic        host_wake_request, ref_clk_request, serial_request_to_send_n;
	logic        bb_tx_active = 1'b0, bb_rx_active = 1'b0, bb_sleep_ok = 1'b0;
	logic        bb_host_attention = 1'b0, wlan_clk_need = 1'b0;
	rf_pd_t      rf_power_down;
	logic        por_active, waitrequest, irq, read = 1'b0, write = 1'b0;
	logic [4:0]  address = 5'h00;
	logic [3:0]  byteenable = 4'h0, lag = 4'h0;
	logic [31:0] writedata = 32'h0000_0000, readdata, q;
	logic        wake_pol = 1'b1, host_need = 1'b0;
	logic [15:0] r = 16'hFFEB;
	logic [7:0]  cv;
	int          mismatches = 0, check_count = 0, i, n;

	always #5 mclk = ~mclk;

	bt_host_power_handshake uut (.mclk, .reset_n, .radio_power_enable, .device_wake_request,
		.serial_clear_to_send_n, .host_wake_request, .ref_clk_request, .serial_request_to_send_n,
		.bb_tx_active, .bb_rx_active, .bb_sleep_ok, .bb_host_attention, .wlan_clk_need, .rf_power_down,
		.por_active, .address, .read, .write, .byteenable, .writedata, .readdata, .waitrequest, .irq);
	bt_host_model host (.mclk, .reset_n, .host_wake_request, .wake_pol, .host_need, .lag,
		.device_wake_request);

	// ==========
	// helpers
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic rf_pd_t exp_pd(input logic t, x, input logic [3:0] f);
		return {~t, ~x, ~(t | x), ~t} | f;
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, g);
		check_count++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", nm, e, g);
			mismatches++;
		end
	endtask
	// no limit of its own: a slave that never answers is caught by the watchdog
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge mclk);
		read <= !w;
		write <= w;
		address <= a;
		writedata <= d;
		byteenable <= 4'hF;
		do begin
			@(posedge mclk);
		end while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task automatic tally_and_finish;
		if (mismatches == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ==========
	// scenarios
	initial begin
		repeat (10) @(posedge mclk);
		reset_n <= 1'b1;
		chk("por_active", 1, por_active);
		bus(1, STATUS_OFS, 32'hFFFF_FFFF);
		bus(1, 5'h18, 32'hFFFF_FFFF);
		for (i = 0; i < 7; i++) begin
			bus(0, 5'(i * 4), 32'h0000_0000);
			chk("reset value", (i == 0) ? 32'h0000_001C : (i == 1) ? 32'h0000_0F04 : 0, q);
		end
		radio_power_enable <= 1'b1;
		for (n = 0; n < T5_CYC && ref_clk_request !== 1'b1; n++) @(posedge mclk);
		chk("ref_clk_request", 1, ref_clk_request);
		serial_clear_to_send_n <= 1'b0;
		repeat (20) @(posedge mclk);
		chk("rts_n before init", 1, serial_request_to_send_n);
		repeat (INIT_CYC) @(posedge mclk);
		serial_clear_to_send_n <= 1'b1;
		repeat (6) @(posedge mclk);
		chk("rts_n idle", 1, serial_request_to_send_n);
		serial_clear_to_send_n <= 1'b0;
		for (n = 0; n < T4_CYC && serial_request_to_send_n !== 1'b0; n++) @(posedge mclk);
		chk("rts_n", 0, serial_request_to_send_n);
		// events are pending here, so a low irq proves the mask works
		chk("irq masked", 0, irq);
		bus(1, IRQ_MASK_OFS, 32'h0000_000C);
		repeat (2) @(posedge mclk);
		chk("irq", 1, irq);
		bus(0, IRQ_STATUS_OFS, 32'h0000_0000);
		chk("irq_status", 32'h0000_000C, q & 32'h0000_000C);
		bus(1, IRQ_STATUS_OFS, 32'h0000_000C);
		repeat (2) @(posedge mclk);
		chk("irq cleared", 0, irq);
		for (i = 0; i < 8; i++) begin
			r = lfsr(r);
			bb_tx_active <= r[0];
			bb_rx_active <= r[1];
			bus(1, PD_FORCE_OFS, {28'h0, r[7:4]});
			repeat (2) @(posedge mclk);
			chk("rf_power_down", exp_pd(r[0], r[1], r[7:4]), rf_power_down);
		end
		bus(1, PD_FORCE_OFS, 32'h0000_0000);
		for (i = 0; i < 16; i++) begin
			cv = {4'h3, i[3], i[3], i[1:0]};
			wake_pol <= i[3];
			bus(1, PAD_SEL_OFS, {29'h0, i[2], 2'b00});
			bus(1, CTRL_OFS, {24'h0, cv});
			repeat (4) @(posedge mclk);
			n = (i[1:0] == 2'b11 && !i[2]);
			chk("host_wake_request", n ? i[3] : !i[3], host_wake_request);
			bus(0, STATUS_OFS, 32'h0000_0000);
			chk("usable", n, q[ST_USABLE]);
		end
		r = lfsr(r);
		wake_pol <= r[0];
		bb_tx_active <= 1'b0;
		bb_rx_active <= 1'b0;
		bus(1, CTRL_OFS, {24'h0, 4'h5, r[0], r[0], 2'b11});
		// the last loop pass left the pads on another function
		bus(1, PAD_SEL_OFS, 32'h0000_0000);
		bus(1, IRQ_STATUS_OFS, 32'h0000_000F);
		bus(1, IRQ_MASK_OFS, 32'h0000_0002);
		repeat (8) @(posedge mclk);
		bus(0, STATUS_OFS, 32'h0000_0000);
		chk("awake without sleep_ok", 1, q[ST_AWAKE]);
		bb_sleep_ok <= 1'b1;
		repeat (8) @(posedge mclk);
		bus(0, STATUS_OFS, 32'h0000_0000);
		chk("sleeping", 1, q[ST_SLEEP]);
		chk("rf off in sleep", 4'hF, rf_power_down);
		chk("irq slept", 1, irq);
		bus(1, CTRL_OFS, {24'h0, 4'hD, r[0], r[0], 2'b11});
		repeat (2) @(posedge mclk);
		bus(0, STATUS_OFS, 32'h0000_0000);
		chk("forced awake", 2'b01, q[1:0]);
		bus(1, CTRL_OFS, {24'h0, 4'h5, r[0], r[0], 2'b11});
		repeat (4) @(posedge mclk);
		bus(0, STATUS_OFS, 32'h0000_0000);
		chk("asleep again", 1, q[ST_SLEEP]);
		host_need <= 1'b1;
		repeat (8) @(posedge mclk);
		bus(0, STATUS_OFS, 32'h0000_0000);
		chk("woken", 2'b01, q[1:0]);
		host_need <= 1'b0;
		bb_sleep_ok <= 1'b0;
		lag <= {1'b0, r[3:1]};
		// let the stale device wake drain, or it clears the attention at once
		repeat (4) @(posedge mclk);
		bb_host_attention <= 1'b1;
		@(posedge mclk);
		bb_host_attention <= 1'b0;
		for (n = 0; n < 4 && host_wake_request !== r[0]; n++) @(posedge mclk);
		chk("host wake raised", r[0], host_wake_request);
		for (n = 0; n < 30 && host_wake_request === r[0]; n++) @(posedge mclk);
		chk("host wake released", !r[0], host_wake_request);
		radio_power_enable <= 1'b0;
		repeat (5) @(posedge mclk);
		chk("por after power off", 1, por_active);
		chk("ref clk off", 0, ref_clk_request);
		wlan_clk_need <= 1'b1;
		repeat (3) @(posedge mclk);
		chk("ref clk for wlan", 1, ref_clk_request);
		wlan_clk_need <= 1'b0;
		repeat (4) @(posedge mclk);
		tally_and_finish;
	end

	// the whole run needs about 600 cycles
	initial begin
		repeat (5000) @(posedge mclk);
		mismatches++;
		tally_and_finish;
	end
endmodule
`default_nettype wire
